//--- src/blhc_pkg.sv
// package for the bus lock / hold / burst-last control block
// assumes a single 40 MHz system clock and a synchronous active-high reset
package blhc_pkg;

  // ---------------------------------------------------------------------
  // sizes and counts
  // ---------------------------------------------------------------------
  localparam int         DATA_W         = 16;       // multiplexed data lanes
  localparam int         BEAT_W         = 3;        // beat index, bursts of up to eight beats
  localparam int         CHECK_WORDS    = 8;        // words summed by the memory checksum
  localparam int         SYNC_STAGES    = 2;        // flip-flops in each pin synchroniser
  localparam int         RESET_MIN_DOUBLE_RATE_CLOCK = 41;       // least reset length in double-rate clocks
  localparam logic [1:0] LANES_NONE_N   = 2'h3;     // both byte lanes idle (active low)
  localparam logic [1:0] LANES_ALL      = 2'h3;     // both byte lanes take part
  localparam logic [DATA_W-1:0] SUM_ZERO = 16'h0000;

  // ---------------------------------------------------------------------
  // transaction kinds and bus states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_ATOMIC_READ,
    KIND_ATOMIC_WRITE,
    KIND_INT_ACK
  } blhc_kind_e;

  typedef enum logic [3:0] {
    ST_INIT_TEST,
    ST_IDLE,
    ST_LOCK_WAIT,
    ST_ADDR,
    ST_DATA,
    ST_HOLD_FLOAT,
    ST_HOLD,
    ST_FAILED
  } blhc_state_e;

endpackage : blhc_pkg

//--- src/blhc_sync_if.sv
// carrier between the top module and its pin synchroniser
// assumes raw pin levels in and synchronised levels back, one clock domain
`timescale 1ns/1ps
interface blhc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : blhc_sync_if

//--- src/blhc_sync.sv
// two-flip-flop synchroniser, one chain per bit
// assumes inputs asynchronous to clk; no reset so a strap can be seen during reset
`timescale 1ns/1ps
module blhc_sync (
  input wire logic clk,
  blhc_sync_if.sync sig
);
  import blhc_pkg::*;

  localparam int W = $bits(sig.raw);

  // ---------------------------------------------------------------------
  // per-bit chains; the first stage feeds only the second
  // ---------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic stable;
      logic next_meta;
      logic next_stable;
      // next values of the chain
      always_comb begin
        next_meta   = sig.raw[i];
        next_stable = meta;
      end
      // register only
      always_ff @(posedge clk) begin
        meta   <= next_meta;
        stable <= next_stable;
      end
      assign sig.synced[i] = stable;
    end
  endgenerate

endmodule : blhc_sync

//--- src/blhc_bus_ctrl.sv
// bus lock, hold handshake, byte-lane enables and burst-last / init-failure control
// assumes core requests on CLK_SYS, pins synchronised here, open-drain lock pulled up outside
//
// Notes on behaviour
// - atomic start samples lock; waits while another agent holds it
// - lock found free, device drives lock in the read's address state
// - lock released in the address state of the atomic write
// - lock is shared open drain; device only pulls low, watches others
// - lock also driven throughout interrupt-acknowledge transactions
// - lock low at reset end selects float-all until next reset
// - two active-low lane enables; upper for high byte, lower for low byte
// - in each data state exactly the participating lanes are enabled
// - on hold request, float bus first, then raise grant, enter hold
// - hold withdrawn drops grant and returns to idle
// - grant floats only in float-all mode and is driven low during reset
// - burst-last low in final data state including its wait states
// - failure shows as burst-last low, lanes idle, between reset and first cycle
// - failure held during self-test, dropped when it passes
// - zero checksum of eight words; mismatch fails for good
// - address strobe low in address state, high in the following data state
`timescale 1ns/1ps
module blhc_bus_ctrl #(
  parameter int DW = blhc_pkg::DATA_W
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  // core side
  input  wire logic                      REQ_VALID,
  input  wire blhc_pkg::blhc_kind_e      REQ_KIND,
  input  wire logic [blhc_pkg::BEAT_W-1:0] REQ_BEATS,
  input  wire logic [1:0]                REQ_LANES,
  output wire logic                      REQ_READY,
  output logic                           DONE,
  output logic                           RD_VALID,
  output logic [DW-1:0]                  RD_DATA,
  input  wire logic                      SELFTEST_DONE,
  input  wire logic                      SELFTEST_PASS,
  output logic                           FLOAT_ALL,
  // pins
  input  wire logic                      HOLD,
  input  wire logic                      READY_N,
  input  wire logic [DW-1:0]             DATA_IN,
  input  wire logic                      LOCK_N_I,
  output wire logic                      LOCK_N_O,
  output logic                           LOCK_N_OE,
  output logic                           BUS_GRANT_ACK,
  output logic                           BUS_GRANT_ACK_OE,
  output logic                           ADDR_STROBE_N,
  output logic [1:0]                     BYTE_LANE_SEL_N,
  output logic                           FINAL_BEAT_N,
  output logic                           BUS_OE
);
  import blhc_pkg::*;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  blhc_sync_if #(.W(DW + 3)) pins ();
  assign pins.raw = {DATA_IN, LOCK_N_I, READY_N, HOLD};

  blhc_sync u_sync (
    .clk (CLK_SYS),
    .sig (pins)
  );

  logic          hold_s;
  logic          ready_s;
  logic          lock_free;
  logic [DW-1:0] data_s;
  assign hold_s    = pins.synced[0];
  assign ready_s   = ~pins.synced[1];
  assign lock_free = pins.synced[2];  // high when no agent pulls lock
  assign data_s    = pins.synced[DW+2:3];

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  blhc_state_e             state, next_state;
  blhc_kind_e              kind, next_kind;
  logic [BEAT_W-1:0]       beat, next_beat;
  logic [BEAT_W-1:0]       last, next_last;
  logic [1:0]              lanes, next_lanes;
  logic                    own_lock, next_own_lock;
  logic                    checking, next_checking;
  logic [DW-1:0]           sum, next_sum;
  logic [DW-1:0]           sum_after;
  logic                    float_all, next_float_all;
  logic                    next_done, next_rd_valid;
  logic [DW-1:0]           next_rd_data;
  logic                    next_lock_oe, next_bus_grant_ack, next_bus_grant_ack_oe;
  logic                    next_as_n, next_final_n, next_bus_oe;
  logic [1:0]              next_lanes_n;
  logic                    is_lock_kind;

  // open drain: the lock pin is only ever pulled low
  assign LOCK_N_O  = 1'b0;
  assign sum_after = DW'(sum + data_s);

  // hold outranks a new request; no grant while an atomic pair holds lock
  assign REQ_READY = (state == ST_IDLE) && !float_all && !(hold_s && !own_lock);
  assign is_lock_kind = (REQ_KIND == KIND_ATOMIC_READ) || (REQ_KIND == KIND_INT_ACK);

  // ---------------------------------------------------------------------
  // next-state and output computation
  // ---------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_kind      = kind;
    next_beat      = beat;
    next_last      = last;
    next_lanes     = lanes;
    next_own_lock  = own_lock;
    next_checking  = checking;
    next_sum       = sum;
    next_float_all = float_all;
    next_done      = 1'b0;
    next_rd_valid  = 1'b0;
    next_rd_data   = RD_DATA;
    case (state)
      ST_INIT_TEST: begin
        if (SELFTEST_DONE) begin
          if (SELFTEST_PASS) begin
            // checksum burst over the first words of memory
            next_state    = ST_ADDR;
            next_kind     = KIND_READ;
            next_beat     = '0;
            next_last     = BEAT_W'(CHECK_WORDS - 1);
            next_lanes    = LANES_ALL;
            next_sum      = SUM_ZERO;
            next_checking = 1'b1;
          end else begin
            next_state = ST_FAILED;
          end
        end
      end
      ST_IDLE: begin
        if (hold_s && !own_lock && !float_all) begin
          next_state = ST_HOLD_FLOAT;
        end else if (REQ_VALID && REQ_READY) begin
          next_kind  = REQ_KIND;
          next_beat  = '0;
          next_last  = REQ_BEATS;
          next_lanes = REQ_LANES;
          if (is_lock_kind && !lock_free) begin
            next_state = ST_LOCK_WAIT;
          end else begin
            next_state = ST_ADDR;
          end
        end
      end
      ST_LOCK_WAIT: begin
        // another agent holds lock; wait for its release
        if (lock_free) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_state = ST_DATA;
      end
      ST_DATA: begin
        if (ready_s) begin
          if (checking) begin
            next_sum = sum_after;
          end else if (kind != KIND_WRITE && kind != KIND_ATOMIC_WRITE) begin
            next_rd_data  = data_s;
            next_rd_valid = 1'b1;
          end
          if (beat == last) begin
            if (checking) begin
              next_checking = 1'b0;
              next_state    = (sum_after == SUM_ZERO) ? ST_IDLE : ST_FAILED;
            end else begin
              next_done  = 1'b1;
              next_state = ST_IDLE;
              if (kind == KIND_INT_ACK) begin
                next_own_lock = 1'b0;
              end
            end
          end else begin
            next_beat = BEAT_W'(beat + 1'b1);
          end
        end
        // no ready: stay, which is the wait state
      end
      ST_HOLD_FLOAT: begin
        next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (!hold_s) begin
          next_state = ST_IDLE;
        end
      end
      ST_FAILED: begin
        next_state = ST_FAILED;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // lock taken in the read's address state, dropped in the write's
    if (next_state == ST_ADDR) begin
      if (next_kind == KIND_ATOMIC_READ || next_kind == KIND_INT_ACK) begin
        next_own_lock = 1'b1;
      end else if (next_kind == KIND_ATOMIC_WRITE) begin
        next_own_lock = 1'b0;
      end
    end

    // reset: last lock level seen under reset chooses float-all
    if (RST) begin
      next_state     = ST_INIT_TEST;
      next_kind      = KIND_READ;
      next_beat      = '0;
      next_last      = '0;
      next_lanes     = '0;
      next_own_lock  = 1'b0;
      next_checking  = 1'b0;
      next_sum       = SUM_ZERO;
      next_float_all = !lock_free;
      next_rd_data   = '0;
    end

    // registered pin values, decoded from the coming state
    next_as_n    = !(next_state == ST_ADDR) || RST;
    next_lanes_n = (next_state == ST_DATA) ? ~next_lanes : LANES_NONE_N;
    next_final_n = !(((next_state == ST_DATA) && (next_beat == next_last)) ||
                     next_state == ST_INIT_TEST || next_state == ST_FAILED) || RST;
    next_bus_oe  = !RST && !next_float_all &&
                   !(next_state == ST_HOLD_FLOAT || next_state == ST_HOLD);
    next_bus_grant_ack    = !RST && (next_state == ST_HOLD);
    // float-all overrides even the grant line, which otherwise always drives
    next_bus_grant_ack_oe = RST || !next_float_all;
    next_lock_oe = next_own_lock && !next_float_all && !RST;
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    state            <= next_state;
    kind             <= next_kind;
    beat             <= next_beat;
    last             <= next_last;
    lanes            <= next_lanes;
    own_lock         <= next_own_lock;
    checking         <= next_checking;
    sum              <= next_sum;
    float_all        <= next_float_all;
    DONE             <= next_done;
    RD_VALID         <= next_rd_valid;
    RD_DATA          <= next_rd_data;
    ADDR_STROBE_N    <= next_as_n;
    BYTE_LANE_SEL_N  <= next_lanes_n;
    FINAL_BEAT_N     <= next_final_n;
    BUS_OE           <= next_bus_oe;
    BUS_GRANT_ACK    <= next_bus_grant_ack;
    BUS_GRANT_ACK_OE <= next_bus_grant_ack_oe;
    LOCK_N_OE        <= next_lock_oe;
  end

  assign FLOAT_ALL = float_all;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  lock_wait_entry_a: assert property (
    (state == ST_IDLE && REQ_VALID && REQ_READY && !(hold_s && !own_lock) &&
     is_lock_kind && !lock_free) |=> (state == ST_LOCK_WAIT) && !LOCK_N_OE)
    else $error("atomic start did not wait for held lock");

  lock_take_a: assert property (
    (!ADDR_STROBE_N && kind == KIND_ATOMIC_READ && !float_all) |-> LOCK_N_OE)
    else $error("lock not driven in atomic read address state");

  lock_drop_a: assert property (
    (!ADDR_STROBE_N && kind == KIND_ATOMIC_WRITE) |-> !LOCK_N_OE)
    else $error("lock still driven in atomic write address state");

  int_ack_lock_a: assert property (
    (state == ST_DATA && kind == KIND_INT_ACK && !float_all) |-> LOCK_N_OE)
    else $error("lock dropped during interrupt acknowledge");

  float_all_a: assert property (
    (float_all && !$past(RST)) |-> !BUS_OE && !LOCK_N_OE && !BUS_GRANT_ACK_OE &&
    $stable(float_all)) else $error("float-all mode left an output driven");

  data_lanes_a: assert property (
    (state == ST_DATA) |-> (BYTE_LANE_SEL_N == ~lanes) && !ADDR_STROBE_N == 1'b0)
    else $error("lane enables do not match the transfer");

  grant_order_a: assert property (
    $rose(BUS_GRANT_ACK) |-> !BUS_OE && !$past(BUS_OE) && $past(state) == ST_HOLD_FLOAT)
    else $error("grant raised before bus floated");

  grant_release_a: assert property (
    (state == ST_HOLD && !hold_s) |=> !BUS_GRANT_ACK && state == ST_IDLE)
    else $error("grant not dropped after hold withdrawn");

  grant_reset_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
    RST |=> !BUS_GRANT_ACK && BUS_GRANT_ACK_OE)
    else $error("grant not driven low during reset");

  final_beat_a: assert property (
    (state == ST_DATA && beat == last) |-> !FINAL_BEAT_N)
    else $error("burst-last missing on final data state");

  init_fail_a: assert property (
    (!$past(RST) && (state == ST_INIT_TEST || state == ST_FAILED)) |->
      !FINAL_BEAT_N && BYTE_LANE_SEL_N == LANES_NONE_N && ADDR_STROBE_N)
    else $error("failure indication wrong");

  sum_fail_a: assert property (
    (state == ST_DATA && checking && ready_s && beat == last && sum_after != SUM_ZERO)
      |=> state == ST_FAILED ##1 state == ST_FAILED)
    else $error("checksum mismatch not held as failure");

  strobe_pulse_a: assert property (
    !ADDR_STROBE_N |=> ADDR_STROBE_N && state == ST_DATA)
    else $error("address strobe not released in data state");

  wait_state_a: assert property (
    (state == ST_DATA && !ready_s) |=> state == ST_DATA && $stable(beat))
    else $error("data state not extended without ready");

  hold_quiet_a: assert property (
    (state == ST_HOLD) |-> !REQ_READY && !BUS_OE && ADDR_STROBE_N)
    else $error("bus active while granted");

endmodule : blhc_bus_ctrl

//--- bench/blhc_agent.sv
// far-side bus agent and memory model for the bus control block
// assumes one clock; a data phase is any cycle with a lane enable low while the bus is driven
`timescale 1ns/1ps
module blhc_agent (
  input  wire logic        clk_sys,
  input  wire logic [1:0]  byte_lane_sel_n,
  input  wire logic        bus_oe,
  input  wire logic [3:0]  waits,
  input  wire logic [15:0] word,
  output logic             ready_n,
  output logic [15:0]      data_in
);
  logic [3:0] cnt;
  logic       in_data;

  assign in_data = bus_oe && (byte_lane_sel_n != 2'h3);
  // wait counter restarts with each fresh data phase, saturates so it never wraps
  always_ff @(posedge clk_sys) begin
    cnt <= in_data ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
  end
  // ready held back for a set number of cycles to make slow memory
  assign ready_n = !(in_data && (cnt >= waits));
  // released data lines show the inverse word, never a stale copy
  assign data_in = in_data ? word : ~word;
endmodule : blhc_agent

//--- bench/tb_top.sv
// self-checking bench for the bus lock / hold / burst-last control block
// assumes the agent model answers bus cycles; lock is open drain with a pull-up here
`timescale 1ns/1ps
module tb_top;
  import blhc_pkg::*;
  logic        clk_sys    = 1'b0;
  logic        rst        = 1'b1;
  logic        req_valid  = 1'b0;
  blhc_kind_e  req_kind   = KIND_READ;
  logic [2:0]  req_beats  = 3'h0;
  logic [1:0]  req_lanes  = 2'h3;
  logic        st_done    = 1'b0;
  logic        st_pass    = 1'b0;
  logic        hold       = 1'b0;
  logic        other_lock = 1'b0;
  logic [3:0]  waits      = 4'h0;
  logic [15:0] word       = 16'h2000;
  logic        req_ready, done, rd_valid, float_all, ready_n, lock_n_o, lock_n_oe;
  logic        grant, grant_oe, as_n, final_n, bus_oe;
  logic [15:0] rd_data, data_in;
  logic [1:0]  lanes_n;
  wire         lock_pin;
  int          num_errors = 0;
  int          checks     = 0;

  always #12.5 clk_sys = ~clk_sys;
  // wired-and of both pull-downs on the shared lock line
  // an undriven enable counts as released, so the pull-up wins before the first edge
  assign lock_pin = !((lock_n_oe === 1'b1 && lock_n_o === 1'b0) || other_lock);

  blhc_bus_ctrl i_blhc_bus_ctrl (
    .CLK_SYS(clk_sys), .RST(rst), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
    .REQ_BEATS(req_beats), .REQ_LANES(req_lanes), .REQ_READY(req_ready), .DONE(done),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .SELFTEST_DONE(st_done),
    .SELFTEST_PASS(st_pass), .FLOAT_ALL(float_all), .HOLD(hold), .READY_N(ready_n),
    .DATA_IN(data_in), .LOCK_N_I(lock_pin), .LOCK_N_O(lock_n_o), .LOCK_N_OE(lock_n_oe),
    .BUS_GRANT_ACK(grant), .BUS_GRANT_ACK_OE(grant_oe), .ADDR_STROBE_N(as_n),
    .BYTE_LANE_SEL_N(lanes_n), .FINAL_BEAT_N(final_n), .BUS_OE(bus_oe));

  blhc_agent i_blhc_agent (
    .clk_sys(clk_sys), .byte_lane_sel_n(lanes_n), .bus_oe(bus_oe), .waits(waits),
    .word(word), .ready_n(ready_n), .data_in(data_in));

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic do_reset(input logic lock_low, input int n);
    rst = 1'b1;
    other_lock = lock_low;
    waits = 4'h0;
    tick(n);
    check({grant, grant_oe, bus_oe}, 3'h2);
    rst = 1'b0;
    tick(2);
    other_lock = 1'b0;
  endtask : do_reset

  // self-test result, then the checksum burst, judged by the state it leaves
  task automatic init_run(input logic [15:0] w, input logic pass, input logic ok);
    int n_as = 0;
    int n_dat = 0;
    word = w;
    tick(4);
    check({as_n, final_n, lanes_n}, 4'hB);
    st_done = 1'b1;
    st_pass = pass;
    tick(1);
    st_done = 1'b0;
    for (int i = 0; i < 60; i++) begin
      n_as += (as_n === 1'b0);
      n_dat += (lanes_n === 2'h0);
      tick(1);
    end
    check(16'(n_as), 16'(pass));
    check(16'(n_dat >= 8 || !pass), 16'h1);
    check({final_n, lanes_n, req_ready}, ok ? 4'hF : 4'h6);
  endtask : init_run

  // one core transfer with the pins watched every cycle until its end
  task automatic do_req(input blhc_kind_e k, input logic [2:0] b, input logic [1:0] ln);
    logic r = 1'b0;
    logic lk_as = 1'b0;
    logic lk_dat = 1'b1;
    int   n_as = 0;
    int   n_dat = 0;
    int   n_fin = 0;
    int   n_bad = 0;
    int   n_rd = 0;
    req_valid = 1'b1;
    req_kind = k;
    req_beats = b;
    req_lanes = ln;
    for (int i = 0; i < 100 && !r; i++) begin
      r = (req_ready === 1'b1);
      tick(1);
    end
    req_valid = 1'b0;
    for (int i = 0; i < 200; i++) begin
      if (as_n === 1'b0) begin
        n_as++;
        lk_as = lock_n_oe;
      end
      if (lanes_n !== 2'h3) begin
        n_dat++;
        n_bad += (lanes_n !== ~ln);
        n_fin += (final_n === 1'b0);
        lk_dat = lk_dat & lock_n_oe;
      end else n_bad += (final_n === 1'b0);
      n_rd += (rd_valid === 1'b1);
      if (done === 1'b1) break;
      tick(1);
    end
    check({r, done}, 2'h3);
    check(16'(n_as), 16'h1);
    check(16'(n_bad), 16'h0);
    check(16'(n_dat >= b + 1 && n_fin >= 1 && n_dat - n_fin >= b), 16'h1);
    check({lk_as, lk_dat}, {2{k == KIND_ATOMIC_READ || k == KIND_INT_ACK}});
    if (k == KIND_READ || k == KIND_ATOMIC_READ) check(rd_data, word);
    if (k == KIND_READ) check(16'(n_rd), 16'(b) + 16'h1);
    tick(1);
  endtask : do_req

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic test_bursts;
    for (int i = 0; i < 3; i++) begin
      waits = 4'(i * 2);
      do_req(KIND_READ, 3'(i * 3 + 1), 2'(i + 1));
      do_req(KIND_WRITE, 3'(7 - i), 2'(3 - i));
    end
    do_req(KIND_INT_ACK, 3'h0, 2'h3);
    do_req(KIND_READ, 3'h0, 2'h1);
  endtask : test_bursts

  task automatic test_lock_wait;
    int bad = 0;
    other_lock = 1'b1;
    // the held line needs two edges through the synchroniser before the request
    tick(2);
    fork
      do_req(KIND_ATOMIC_READ, 3'h0, 2'h3);
      begin
        for (int i = 0; i < 20; i++) begin
          bad += (as_n === 1'b0);
          tick(1);
        end
        check(16'(bad), 16'h0);
        other_lock = 1'b0;
      end
    join
    do_req(KIND_ATOMIC_WRITE, 3'h1, 2'h3);
  endtask : test_lock_wait

  task automatic test_hold;
    logic prev = 1'b1;
    int   bad = 0;
    hold = 1'b1;
    for (int i = 0; i < 10 && grant !== 1'b1; i++) begin
      prev = bus_oe;
      tick(1);
    end
    check({grant, grant_oe, prev, bus_oe}, 4'hC);
    fork
      do_req(KIND_READ, 3'h2, 2'h3);
      begin
        for (int i = 0; i < 12; i++) begin
          bad += (as_n === 1'b0 || bus_oe !== 1'b0 || grant !== 1'b1);
          tick(1);
        end
        check(16'(bad), 16'h0);
        hold = 1'b0;
        tick(4);
        check({grant, bus_oe}, 2'h1);
      end
    join
  endtask : test_hold

  task automatic test_init_fail;
    do_reset(1'b0, 21);
    init_run(16'h1234, 1'b1, 1'b0);
    do_reset(1'b0, 21);
    init_run(16'h2000, 1'b0, 1'b0);
  endtask : test_init_fail

  task automatic test_float;
    do_reset(1'b1, 21);
    tick(20);
    check({float_all, bus_oe, grant_oe}, 3'h4);
    do_reset(1'b0, 21);
    check(float_all, 1'b0);
    init_run(16'h2000, 1'b1, 1'b1);
  endtask : test_float

  initial begin
    do_reset(1'b0, 3);
    init_run(16'h2000, 1'b1, 1'b1);
    test_bursts();
    test_lock_wait();
    test_hold();
    test_init_fail();
    test_float();
    give_verdict();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 8000);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
